/* File: hdl/rotate_skip_cfg.svh */
// offsets, field positions, reset values and counts for the rotate/skip/return unit
// assumes a 32-bit classic wishbone bus with byte addresses on wb_adr_i
`ifndef ROTATE_SKIP_CFG_SVH
`define ROTATE_SKIP_CFG_SVH

`define ADR_W 8
`define DATA_W 8
`define PC_W 12
`define MEM_DEPTH 8
`define MEM_IDX_W 3

`define OFS_CTRL 8'h00
`define OFS_ACC 8'h04
`define OFS_FLAGS 8'h08
`define OFS_PC 8'h0c
`define OFS_STACK_TOP 8'h10
`define OFS_EXEC_STAT 8'h14
`define OFS_MEM_BASE 8'h20
`define MEM_BASE_HI 3'h1

`define CTRL_OP_LSB 0
`define CTRL_TO_ACC_BIT 4
`define CTRL_BIT_LSB 5
`define CTRL_IDX_LSB 8
`define CTRL_IMM_LSB 16

`define FLAG_C_BIT 0
`define FLAG_HC_BIT 1
`define FLAG_Z_BIT 2
`define FLAG_OV_BIT 3
`define FLAG_MIE_BIT 4

`define STAT_BUSY_BIT 0
`define STAT_SKIP_BIT 1
`define STAT_CYC_LSB 2

`define RST_ACC 8'h00
`define RST_PC 12'h000
`define RST_MEM 8'h00
`define ALL_ONES 8'hff
`define ONE_CYCLE 2'h1
`define TWO_CYCLES 2'h2

`endif

/* File: hdl/rotate_skip_pkg.sv */
// types of the rotate/skip/return unit
// constants live in rotate_skip_cfg.svh
package rotate_skip_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SUBROUTINE_EXIT = 4'h1,
    OP_EXIT_IMM = 4'h2,
    OP_INTERRUPT_EXIT = 4'h3,
    OP_RL = 4'h4,
    OP_RLC = 4'h5,
    OP_RR = 4'h6,
    OP_RRC = 4'h7,
    OP_BORROW_SUBTRACT = 4'h8,
    OP_DSKIP = 4'h9,
    OP_ISKIP = 4'ha,
    OP_SET_BYTE = 4'hb,
    OP_SET_BIT = 4'hc,
    OP_BNZ_SKIP = 4'hd
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DUMMY = 2'b10
  } state_e;

endpackage : rotate_skip_pkg

/* File: hdl/rotate_skip_unit.sv */
// execution unit for returns, rotates, borrow subtract, set and skip operations
// assumes a classic wishbone master, one clock, synchronous active-high reset
//
// How it works
// - return reloads pc, two cycles, flags kept
// - immediate return reloads pc, loads accumulator
// - interrupt return reloads pc, sets enable
// - left rotate to memory, bit7 to bit0
// - left rotate into accumulator, memory kept
// - nine-bit left rotate through carry to memory
// - nine-bit left rotate into accumulator
// - right rotate to memory, bit0 to bit7
// - right rotate into accumulator, memory kept
// - right rotate through carry to memory
// - right rotate through carry into accumulator
// - borrow subtract into accumulator, four flags
// - borrow subtract into memory, four flags
// - decrement memory, skip on zero
// - decrement into accumulator, skip on zero
// - increment memory, skip on zero
// - increment into accumulator, skip on zero
// - byte set writes all ones
// - bit set forces one bit only
// - skip when selected bit is one
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "rotate_skip_cfg.svh"

module rotate_skip_unit
  import rotate_skip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy_o,
  output logic [`PC_W-1:0] pc_o,
  output logic [`DATA_W-1:0] acc_o
);

  state_e state, next_state;
  op_e op, next_op;
  logic to_acc, next_to_acc;
  logic [2:0] bit_sel, next_bit_sel;
  logic [`MEM_IDX_W-1:0] op_idx, next_op_idx;
  logic [`DATA_W-1:0] imm, next_imm;
  logic [`DATA_W-1:0] acc, next_acc;
  logic [`PC_W-1:0] pc, next_pc;
  logic [`PC_W-1:0] stack_top, next_stack_top;
  logic carry, next_carry;
  logic half_carry_flag, next_half_carry_flag;
  logic zero_flag, next_zero_flag;
  logic overflow_flag, next_overflow_flag;
  logic master_interrupt_enable, next_master_interrupt_enable;
  logic last_skip, next_last_skip;
  logic [1:0] last_cycles, next_last_cycles;
  logic dummy_inc, next_dummy_inc;
  logic busy, next_busy;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic [`DATA_W-1:0] mem [`MEM_DEPTH];
  logic [`DATA_W-1:0] next_mem [`MEM_DEPTH];
  logic mem_we, go;
  logic [`MEM_IDX_W-1:0] mem_widx;
  logic [`DATA_W-1:0] mem_wval, src;

  assign src = mem[op_idx];
  assign go = ce_i && (state == ST_EXEC);

  // merge bus write data into an old word under the byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // per-entry next value of data memory
  for (genvar gi = 0; gi < `MEM_DEPTH; gi++) begin : g_mem
    always_comb begin
      next_mem[gi] = mem[gi];
      if (mem_we && (mem_widx == `MEM_IDX_W'(gi))) begin
        next_mem[gi] = mem_wval;
      end
    end
  end

  always_comb begin
    logic req, wr, res_valid, skip, two;
    logic [31:0] w;
    logic [8:0] diff;
    logic [4:0] half;
    logic [`DATA_W-1:0] res;
    req = wb_cyc_i && wb_stb_i && !ack;
    wr = req && wb_we_i && (state == ST_IDLE);
    w = 32'h0000_0000;
    diff = 9'h000;
    half = 5'h00;
    res = src;
    res_valid = 1'b0;
    skip = 1'b0;
    two = 1'b0;
    next_state = state;
    next_op = op;
    next_to_acc = to_acc;
    next_bit_sel = bit_sel;
    next_op_idx = op_idx;
    next_imm = imm;
    next_acc = acc;
    next_pc = pc;
    next_stack_top = stack_top;
    next_carry = carry;
    next_half_carry_flag = half_carry_flag;
    next_zero_flag = zero_flag;
    next_overflow_flag = overflow_flag;
    next_master_interrupt_enable = master_interrupt_enable;
    next_last_skip = last_skip;
    next_last_cycles = last_cycles;
    next_dummy_inc = dummy_inc;
    mem_we = 1'b0;
    mem_widx = op_idx;
    mem_wval = src;
    next_ack = req;
    next_rdat = 32'h0000_0000;

    // register reads, unmapped offsets read zero
    if (req && !wb_we_i) begin
      if (wb_adr_i[7:5] == `MEM_BASE_HI) begin
        next_rdat = {24'h00_0000, mem[wb_adr_i[4:2]]};
      end else begin
        case (wb_adr_i)
          `OFS_CTRL: next_rdat = {8'h00, imm, 5'h00, op_idx, bit_sel, to_acc, op};
          `OFS_ACC: next_rdat = {24'h00_0000, acc};
          `OFS_FLAGS: next_rdat = {27'h000_0000, master_interrupt_enable, overflow_flag,
                                   zero_flag, half_carry_flag, carry};
          `OFS_PC: next_rdat = {20'h0_0000, pc};
          `OFS_STACK_TOP: next_rdat = {20'h0_0000, stack_top};
          `OFS_EXEC_STAT: next_rdat = {28'h000_0000, last_cycles, last_skip, busy};
          default: next_rdat = 32'h0000_0000;
        endcase
      end
    end

    // register writes are ignored while an operation runs
    if (wr) begin
      if (wb_adr_i[7:5] == `MEM_BASE_HI) begin
        w = merge({24'h00_0000, mem[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i);
        mem_we = 1'b1;
        mem_widx = wb_adr_i[4:2];
        mem_wval = w[7:0];
      end else begin
        case (wb_adr_i)
          `OFS_CTRL: begin
            w = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
            next_op = op_e'(w[`CTRL_OP_LSB +: 4]);
            next_to_acc = w[`CTRL_TO_ACC_BIT];
            next_bit_sel = w[`CTRL_BIT_LSB +: 3];
            next_op_idx = w[`CTRL_IDX_LSB +: `MEM_IDX_W];
            next_imm = w[`CTRL_IMM_LSB +: `DATA_W];
            next_state = ST_EXEC;
          end
          `OFS_ACC: begin
            w = merge({24'h00_0000, acc}, wb_dat_i, wb_sel_i);
            next_acc = w[7:0];
          end
          `OFS_FLAGS: begin
            w = merge({27'h000_0000, master_interrupt_enable, overflow_flag, zero_flag,
                       half_carry_flag, carry}, wb_dat_i, wb_sel_i);
            next_carry = w[`FLAG_C_BIT];
            next_half_carry_flag = w[`FLAG_HC_BIT];
            next_zero_flag = w[`FLAG_Z_BIT];
            next_overflow_flag = w[`FLAG_OV_BIT];
            next_master_interrupt_enable = w[`FLAG_MIE_BIT];
          end
          `OFS_PC: begin
            w = merge({20'h0_0000, pc}, wb_dat_i, wb_sel_i);
            next_pc = w[`PC_W-1:0];
          end
          `OFS_STACK_TOP: begin
            w = merge({20'h0_0000, stack_top}, wb_dat_i, wb_sel_i);
            next_stack_top = w[`PC_W-1:0];
          end
          default: w = 32'h0000_0000;
        endcase
      end
    end

    case (state)
      ST_IDLE: ;
      ST_EXEC: begin
        next_pc = pc + `PC_W'(1);
        case (op)
          OP_SUBROUTINE_EXIT, OP_EXIT_IMM, OP_INTERRUPT_EXIT: begin
            next_pc = stack_top;
            two = 1'b1;
            if (op == OP_EXIT_IMM) next_acc = imm;
            if (op == OP_INTERRUPT_EXIT) next_master_interrupt_enable = 1'b1;
          end
          OP_RL: begin
            res = {src[6:0], src[7]};
            res_valid = 1'b1;
          end
          OP_RLC: begin
            res = {src[6:0], carry};
            next_carry = src[7];
            res_valid = 1'b1;
          end
          OP_RR: begin
            res = {src[0], src[7:1]};
            res_valid = 1'b1;
          end
          OP_RRC: begin
            res = {carry, src[7:1]};
            next_carry = src[0];
            res_valid = 1'b1;
          end
          OP_BORROW_SUBTRACT: begin
            diff = {1'b0, acc} + {1'b0, ~src} + {8'h00, carry};
            half = {1'b0, acc[3:0]} + {1'b0, ~src[3:0]} + {4'h0, carry};
            res = diff[7:0];
            res_valid = 1'b1;
            next_carry = diff[8];
            next_half_carry_flag = half[4];
            next_zero_flag = (diff[7:0] == 8'h00);
            next_overflow_flag = (acc[7] == ~src[7]) && (diff[7] != acc[7]);
          end
          OP_DSKIP: begin
            res = src - `DATA_W'(1);
            res_valid = 1'b1;
            skip = (res == 8'h00);
          end
          OP_ISKIP: begin
            res = src + `DATA_W'(1);
            res_valid = 1'b1;
            skip = (res == 8'h00);
          end
          OP_SET_BYTE: begin
            mem_we = 1'b1;
            mem_wval = `ALL_ONES;
          end
          OP_SET_BIT: begin
            mem_we = 1'b1;
            mem_wval = src | (8'h01 << bit_sel);
          end
          OP_BNZ_SKIP: begin
            skip = src[bit_sel];
          end
          default: ;
        endcase
        // accumulator variants leave the memory byte alone
        if (res_valid) begin
          if (to_acc) begin
            next_acc = res;
          end else begin
            mem_we = 1'b1;
            mem_wval = res;
          end
        end
        // taken skip discards the prefetched instruction with a dummy cycle
        next_last_skip = skip;
        next_dummy_inc = skip;
        next_last_cycles = (two || skip) ? `TWO_CYCLES : `ONE_CYCLE;
        next_state = (two || skip) ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        if (dummy_inc) begin
          next_pc = pc + `PC_W'(1);
        end
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      op <= OP_NOP;
      to_acc <= 1'b0;
      bit_sel <= 3'h0;
      op_idx <= '0;
      imm <= `RST_ACC;
      acc <= `RST_ACC;
      pc <= `RST_PC;
      stack_top <= `RST_PC;
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      overflow_flag <= 1'b0;
      master_interrupt_enable <= 1'b0;
      last_skip <= 1'b0;
      last_cycles <= 2'h0;
      dummy_inc <= 1'b0;
      busy <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
      mem <= '{default: `RST_MEM};
    end else if (ce_i) begin
      state <= next_state;
      op <= next_op;
      to_acc <= next_to_acc;
      bit_sel <= next_bit_sel;
      op_idx <= next_op_idx;
      imm <= next_imm;
      acc <= next_acc;
      pc <= next_pc;
      stack_top <= next_stack_top;
      carry <= next_carry;
      half_carry_flag <= next_half_carry_flag;
      zero_flag <= next_zero_flag;
      overflow_flag <= next_overflow_flag;
      master_interrupt_enable <= next_master_interrupt_enable;
      last_skip <= next_last_skip;
      last_cycles <= next_last_cycles;
      dummy_inc <= next_dummy_inc;
      busy <= next_busy;
      ack <= next_ack;
      rdat <= next_rdat;
      mem <= next_mem;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign busy_o = busy;
  assign pc_o = pc;
  assign acc_o = acc;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_exit_pc_flags: assert property (
    go && op == OP_SUBROUTINE_EXIT |=> pc == $past(stack_top) && state == ST_DUMMY
      && carry == $past(carry) && zero_flag == $past(zero_flag))
    else $error("return did not reload pc in two cycles");
  a_exit_imm_acc: assert property (
    go && op == OP_EXIT_IMM |=> acc == $past(imm) && pc == $past(stack_top))
    else $error("immediate return wrong accumulator or pc");
  a_int_exit_enable: assert property (
    go && op == OP_INTERRUPT_EXIT |=> master_interrupt_enable && carry == $past(carry))
    else $error("interrupt return did not set enable");
  a_rl_mem_rot: assert property (
    go && op == OP_RL && !to_acc |=> mem[$past(op_idx)] == {$past(src[6:0]), $past(src[7])})
    else $error("left rotate to memory wrong");
  a_rla_keep_mem: assert property (
    go && op == OP_RL && to_acc |=> acc == {$past(src[6:0]), $past(src[7])}
      && mem[$past(op_idx)] == $past(src))
    else $error("left rotate to accumulator wrong");
  a_rlc_carry_out: assert property (
    go && op == OP_RLC |=> carry == $past(src[7]))
    else $error("left rotate through carry lost bit 7");
  a_rrc_nine_bit: assert property (
    go && op == OP_RRC && !to_acc |=> carry == $past(src[0])
      && mem[$past(op_idx)] == {$past(carry), $past(src[7:1])})
    else $error("right rotate through carry wrong");
  a_rr_acc_rot: assert property (
    go && op == OP_RR && to_acc |=> acc == {$past(src[0]), $past(src[7:1])})
    else $error("right rotate to accumulator wrong");
  a_borrow_acc_value: assert property (
    go && op == OP_BORROW_SUBTRACT && to_acc |=> acc == 8'($past(acc) + ~$past(src)
      + $past(carry)) && zero_flag == (acc == 8'h00))
    else $error("borrow subtract result wrong");
  a_skip_dummy_cycle: assert property (
    go && (op == OP_DSKIP || op == OP_ISKIP) |=> (state == ST_DUMMY) == last_skip
      && last_skip == ($past(src) == (($past(op) == OP_DSKIP) ? 8'h01 : 8'hff)))
    else $error("skip did not add a dummy cycle");
  a_dskip_wrap: assert property (
    go && op == OP_DSKIP && to_acc && src == 8'h00 |=> acc == 8'hff && !last_skip)
    else $error("decrement did not wrap");
  a_set_bit_only: assert property (
    go && op == OP_SET_BIT |=> mem[$past(op_idx)] == ($past(src) | (8'h01 << $past(bit_sel))))
    else $error("bit set touched other bits");
  a_bnz_skip_len: assert property (
    go && op == OP_BNZ_SKIP && src[bit_sel] |=> state == ST_DUMMY ##1 !busy)
    else $error("bit test skip length wrong");

  c_exit_done: cover property (go && op == OP_SUBROUTINE_EXIT ##1 ce_i ##1 !busy);
  c_skip_taken: cover property (go && op == OP_ISKIP ##1 last_skip);
  c_borrow_run: cover property (go && op == OP_BORROW_SUBTRACT && to_acc);
  c_bus_read: cover property (wb_ack_o && !wb_we_i);

endmodule : rotate_skip_unit

/* File: tb/testbench.sv */
// self-checking bench for the rotate/skip/return unit
// assumes the unit's wishbone register map, one 40 MHz clock and synchronous reset
`timescale 1ns/10ps
`include "rotate_skip_cfg.svh"

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench
  import rotate_skip_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_val, m_exp;
  logic [3:0] wb_sel_i;
  logic wb_ack_o, busy_o;
  logic [11:0] pc_o;
  logic [7:0] acc_o;
  int mismatches, checks_done;
  integer seed = 32'h95d8;
  logic [31:0] exp_q[$];
  bit chk_q[$];
  string name_q[$];
  bit m_chk;
  string m_nm;

  rotate_skip_unit uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
    .pc_o(pc_o), .acc_o(acc_o));

  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // one classic cycle; the note is queued for the monitor
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input bit chk, input logic [31:0] exp, input string nm);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    exp_q.push_back(exp);
    chk_q.push_back(chk);
    name_q.push_back(nm);
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd_val = wb_dat_o;
    if (n >= 50) begin
      mismatches++;
      $display("[FAIL] ack expected 1 seen 0");
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 1'b0, 32'h0, "write");
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string nm);
    bus(1'b0, adr, 32'h0, 1'b1, exp, nm);
  endtask : rd

  // monitor: every ack takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[FAIL] ack expected 0 seen 1");
      end else begin
        m_exp = exp_q.pop_front();
        m_chk = chk_q.pop_front();
        m_nm = name_q.pop_front();
        if (m_chk)
          `CHK(m_nm, m_exp, wb_dat_o)
      end
    end
  end

  task automatic run_op(input op_e op, input bit ta, input logic [7:0] m,
                        input logic [2:0] idx, input logic [2:0] b);
    logic [7:0] acc, r, em, ea, imm, madr;
    logic [4:0] fl, ef, h;
    logic [11:0] pc, st, ep;
    logic [8:0] s;
    logic [1:0] cyc;
    logic sk, bz1, bz2;
    acc = 8'($random(seed));
    fl = 5'($random(seed));
    pc = 12'($random(seed));
    st = 12'($random(seed));
    imm = 8'($random(seed));
    madr = `OFS_MEM_BASE + {3'h0, idx, 2'h0};
    wr(madr, {24'h0, m});
    wr(`OFS_ACC, {24'h0, acc});
    wr(`OFS_FLAGS, {27'h0, fl});
    wr(`OFS_PC, {20'h0, pc});
    wr(`OFS_STACK_TOP, {20'h0, st});
    wr(`OFS_CTRL, {8'h0, imm, 5'h0, idx, b, ta, op});
    bz1 = busy_o;
    @(posedge clk_i);
    bz2 = busy_o;
    do bus(1'b0, `OFS_EXEC_STAT, 32'h0, 1'b0, 32'h0, "poll"); while (rd_val[0] !== 1'b0);
    `CHK("idle", 1'b0, busy_o)
    em = m;
    ea = acc;
    ef = fl;
    ep = pc + 12'h1;
    cyc = 2'h1;
    sk = 1'b0;
    r = m;
    case (op)
      OP_SUBROUTINE_EXIT, OP_EXIT_IMM, OP_INTERRUPT_EXIT: begin
        ep = st;
        cyc = 2'h2;
        if (op == OP_EXIT_IMM) ea = imm;
        if (op == OP_INTERRUPT_EXIT) ef[4] = 1'b1;
      end
      OP_RL: r = {m[6:0], m[7]};
      OP_RLC: begin
        r = {m[6:0], fl[0]};
        ef[0] = m[7];
      end
      OP_RR: r = {m[0], m[7:1]};
      OP_RRC: begin
        r = {fl[0], m[7:1]};
        ef[0] = m[0];
      end
      OP_BORROW_SUBTRACT: begin
        s = {1'b0, acc} + {1'b0, ~m} + {8'h0, fl[0]};
        h = {1'b0, acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, fl[0]};
        r = s[7:0];
        ef[0] = s[8];
        ef[1] = h[4];
        ef[2] = (r == 8'h0);
        ef[3] = (acc[7] == ~m[7]) && (r[7] != acc[7]);
      end
      OP_DSKIP: begin
        r = m - 8'h1;
        sk = (r == 8'h0);
      end
      OP_ISKIP: begin
        r = m + 8'h1;
        sk = (r == 8'h0);
      end
      OP_SET_BYTE: em = 8'hff;
      OP_SET_BIT: em[b] = 1'b1;
      OP_BNZ_SKIP: sk = m[b];
      default: ;
    endcase
    if (op inside {[OP_RL:OP_ISKIP]}) begin
      if (ta) ea = r;
      else em = r;
    end
    if (sk) begin
      cyc = 2'h2;
      ep = pc + 12'h2;
    end
    rd(madr, {24'h0, em}, "memory");
    rd(`OFS_ACC, {24'h0, ea}, "acc");
    rd(`OFS_FLAGS, {27'h0, ef}, "flags");
    rd(`OFS_PC, {20'h0, ep}, "pc");
    `CHK("pc_o", ep, pc_o)
    `CHK("acc_o", ea, acc_o)
    bus(1'b0, `OFS_EXEC_STAT, 32'h0, 1'b0, 32'h0, "status");
    `CHK("cycles", cyc, rd_val[3:2])
    `CHK("skip", sk, rd_val[1])
    `CHK("busy", 1'b1, bz1)
    `CHK("busy len", cyc == 2'h2, bz2)
  endtask : run_op

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  initial begin
    logic [7:0] m;
    logic [2:0] b;
    op_e op;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_ACC, 32'h0, "acc reset");
    rd(`OFS_FLAGS, 32'h0, "flags reset");
    rd(`OFS_MEM_BASE, 32'h0, "memory reset");
    wr(8'h18, 32'h000000a5);
    rd(8'h18, 32'h0, "unmapped");
    for (int k = 1; k <= 13; k++) begin
      for (int ta = 0; ta < 2; ta++) begin
        for (int v = 0; v < 2; v++) begin
          op = op_e'(4'(k));
          m = 8'($random(seed));
          b = 3'($random(seed));
          if (op == OP_DSKIP) m = v ? 8'h01 : 8'h00;
          if (op == OP_ISKIP && v) m = 8'hff;
          if (op == OP_BNZ_SKIP) m = v ? (8'h01 << b) : ~(8'h01 << b);
          run_op(op, ta[0], m, 3'($random(seed)), b);
        end
      end
    end
    // a low clock enable must hold off the bus answer and every register
    m = acc_o;
    ce_i <= 1'b0;
    fork
      wr(`OFS_ACC, 32'h0000_005a);
      begin
        repeat (3) @(posedge clk_i);
        `CHK("frozen ack", 1'b0, wb_ack_o)
        `CHK("frozen acc", m, acc_o)
        ce_i <= 1'b1;
      end
    join
    rd(`OFS_ACC, 32'h0000_005a, "acc after freeze");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_PC, 32'h0, "pc reset");
    rd(`OFS_ACC, 32'h0, "acc rerun");
    repeat (4) @(posedge clk_i);
    conclude();
  end
endmodule : testbench
